// file: rtl/converter_start_and_control.sv
// Behaviour
// - Software start bit begins exactly one conversion
// - Busy reads one during conversion, auto-clears
// - Trigger select field chooses start source
// - Selected timer overflow starts each conversion
// - Hardware sets and clears busy in timer mode
// - Done flag set on completion, cleared on vector
// - Bit 5 selects DAC or ADC direction
// - Bit 4 enables converter; start needs it
// - Alignment bit: right sign-extend or left zero-fill
// - Clock select: RC/4 or sysclk divided 2..128
// - Control register at D9H, resets zero
// - ADC conversion lasts 13 converter clocks
// - DAC conversion lasts 11 converter clocks
// - ADC end sets done and writes result
//
// The plain strobed port was decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "converter_regs.svh"

// ----------------------------------------
// Operating notes
// ----------------------------------------
// The converter clock is never a real clock here. Every converter
// cycle is a one-cycle enable pulse on the system clock, so all state
// stays in one domain and no handshake between clocks is needed.
// With code 000 the pulse follows every fourth rising edge of the
// oscillator pin, seen through a two-stage synchroniser. That adds
// two to three system cycles of latency and one cycle of jitter. The
// oscillator must run well below half the system clock, or edges
// are lost.
// With codes 001 to 111 the pulse is a tap of a free-running 7-bit
// prescaler. A start does not restart the prescaler, so the first
// converter cycle may be short by up to one period. This trades exact
// phase for a cheaper counter.
// The sequencer counts a conversion in converter cycles. The busy bit
// is a copy of the sequencer state: it rises on the edge that accepts
// the start and falls on the edge that ends the conversion.
// A software start needs enable set by an earlier write. A write that
// sets enable and busy together is taken as enable only.
// Clearing enable while busy abandons the conversion, with no done
// flag and no new result.
// Software cannot write done or busy. Done clears only when the
// interrupt vector is taken. A finish in the same cycle wins, so that
// no completion is lost.
// The status register keeps the done (bit 0) and start (bit 1) events
// as sticky bits, cleared by writing ones. The mask register gates them
// onto the level interrupt output. An event in the same cycle as its
// clear leaves the bit set.
// Timer overflows are pulses from the same clock domain and are not
// synchronised. Overflows that arrive while busy are dropped.
// Results are only taken in converter mode. In output mode the result
// register keeps the last converted value.

module converter_start_and_control
    import converter_pkg::*;
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_reset,
    // Register port
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // Trigger and clock sources
    input wire logic [1:0] i_trigger_select,
    input wire logic i_timer0_ovf,
    input wire logic i_timer1_ovf,
    input wire logic i_timer2_ovf,
    input wire logic i_rc_osc,
    input wire logic i_isr_vector,
    // Converter analog side
    input wire logic [9:0] i_adc_raw,
    output logic [15:0] o_result,
    output logic o_converter_enable,
    output logic o_dac_mode,
    output logic o_conv_clk_en,
    output logic o_busy,
    output logic o_irq
);

    // ----------------------------------------
    // Synchronisers for the RC oscillator pin
    // ----------------------------------------
    logic rc_s1_r, rc_s2_r, rc_s3_r;
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            rc_s1_r <= 1'b0;
            rc_s2_r <= 1'b0;
            rc_s3_r <= 1'b0;
        end else begin
            rc_s1_r <= i_rc_osc;
            rc_s2_r <= rc_s1_r;
            rc_s3_r <= rc_s2_r;
        end
    end

    // ----------------------------------------
    // Result formatting shared by the alignment choice
    // ----------------------------------------
    function automatic logic [15:0] align_result(input logic [9:0] raw, input logic left);
        if (left) begin
            align_result = {raw, 6'h00};
        end else begin
            align_result = {{6{raw[9]}}, raw};
        end
    endfunction

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    logic [7:0] ctrl_r, ctrl_nxt;
    logic [1:0] ista_r, ista_nxt;
    logic [1:0] imask_r, imask_nxt;
    logic [15:0] result_r, result_nxt;
    logic [6:0] presc_r, presc_nxt;
    logic [2:0] rc_cnt_r, rc_cnt_nxt;
    logic [3:0] cyc_r, cyc_nxt;
    conv_state_t state_r, state_nxt;
    logic [7:0] rdata_nxt;

    logic ctrl_wr, tick, rc_rise, timer_ovf, start, finish;
    trigger_t trig;

    // ----------------------------------------
    // Converter clock enable
    // ----------------------------------------
    // RC edges counted by four, or a tap of the free prescaler
    always_comb begin
        rc_rise = rc_s2_r & ~rc_s3_r;
        rc_cnt_nxt = rc_cnt_r;
        presc_nxt = presc_r + 7'h01;
        tick = 1'b0;
        if (ctrl_r[`ACK_MSB:0] == 3'h0) begin
            if (rc_rise) begin
                rc_cnt_nxt = (rc_cnt_r == `RC_DIV - 3'd1) ? 3'd0 : rc_cnt_r + 3'd1;
                tick = (rc_cnt_r == `RC_DIV - 3'd1);
            end
        end else begin
            // Divide by 2^code: low code bits of the prescaler all ones
            tick = ((presc_r | ~((7'h01 << ctrl_r[`ACK_MSB:0]) - 7'h01)) == 7'h7f);
        end
    end

    // ----------------------------------------
    // Start source selection and conversion sequencing
    // ----------------------------------------
    always_comb begin
        trig = trigger_t'(i_trigger_select);
        ctrl_wr = i_wr && i_addr == `CTRL_ADDR;
        case (trig)
            TRIG_T0: timer_ovf = i_timer0_ovf;
            TRIG_T1: timer_ovf = i_timer1_ovf;
            TRIG_T2: timer_ovf = i_timer2_ovf;
            default: timer_ovf = 1'b0;
        endcase
        start = 1'b0;
        finish = 1'b0;
        state_nxt = state_r;
        cyc_nxt = cyc_r;
        case (state_r)
            ST_IDLE: begin
                // Enable must already be set; a write of zero does nothing
                if (ctrl_r[`BIT_EN]) begin
                    if (trig == TRIG_SW) begin
                        start = ctrl_wr && i_wdata[`BIT_BUSY];
                    end else begin
                        start = timer_ovf;
                    end
                end
                if (start) begin
                    state_nxt = ST_CONV;
                    cyc_nxt = 4'd0;
                end
            end
            ST_CONV: begin
                // Overflows and start writes here are ignored
                if (!ctrl_r[`BIT_EN]) begin
                    state_nxt = ST_IDLE; // Disabling aborts without a done flag
                end else if (tick) begin
                    if (cyc_r == (ctrl_r[`BIT_DIR] ? `DAC_CYCLES : `ADC_CYCLES) - 4'd1) begin
                        finish = 1'b1;
                        state_nxt = ST_IDLE;
                    end else begin
                        cyc_nxt = cyc_r + 4'd1;
                    end
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    // ----------------------------------------
    // Control, interrupt and result next values
    // ----------------------------------------
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (ctrl_wr) begin
            // Busy and done are hardware-owned; software writes the rest
            ctrl_nxt[5:0] = i_wdata[5:0];
        end
        ctrl_nxt[`BIT_BUSY] = (state_nxt == ST_CONV);
        if (i_isr_vector) begin
            ctrl_nxt[`BIT_DONE] = 1'b0;
        end
        if (finish) begin
            ctrl_nxt[`BIT_DONE] = 1'b1;
        end
        result_nxt = result_r;
        if (finish && !ctrl_r[`BIT_DIR]) begin
            result_nxt = align_result(i_adc_raw, ctrl_r[`BIT_ALIGN]);
        end
        // Status bit 0 done, bit 1 started; set beats write-one clear
        ista_nxt = ista_r;
        if (i_wr && i_addr == `INT_STATUS_ADDR) begin
            ista_nxt = ista_r & ~i_wdata[1:0];
        end
        ista_nxt = ista_nxt | {start, finish};
        imask_nxt = imask_r;
        if (i_wr && i_addr == `INT_MASK_ADDR) begin
            imask_nxt = i_wdata[1:0];
        end
        rdata_nxt = 8'h00;
        if (i_rd) begin
            case (i_addr)
                `CTRL_ADDR: rdata_nxt = ctrl_r;
                `INT_STATUS_ADDR: rdata_nxt = {6'h00, ista_r};
                `INT_MASK_ADDR: rdata_nxt = {6'h00, imask_r};
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    // ----------------------------------------
    // State registers
    // ----------------------------------------
    // Sequencer and converter clock dividers
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            presc_r <= 7'h00;
            rc_cnt_r <= 3'd0;
            cyc_r <= 4'd0;
            state_r <= ST_IDLE;
        end else begin
            presc_r <= presc_nxt;
            rc_cnt_r <= rc_cnt_nxt;
            cyc_r <= cyc_nxt;
            state_r <= state_nxt;
        end
    end

    // Control register
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            ctrl_r <= `CTRL_RESET;
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    // Interrupt status and mask
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            ista_r <= 2'h0;
            imask_r <= 2'h0;
        end else begin
            ista_r <= ista_nxt;
            imask_r <= imask_nxt;
        end
    end

    // Result and read data; read data stands for one cycle only
    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            result_r <= 16'h0000;
            o_rdata <= 8'h00;
        end else begin
            result_r <= result_nxt;
            o_rdata <= rdata_nxt;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign o_result = result_r;
    assign o_converter_enable = ctrl_r[`BIT_EN];
    assign o_dac_mode = ctrl_r[`BIT_DIR];
    assign o_conv_clk_en = tick;
    assign o_busy = ctrl_r[`BIT_BUSY];
    assign o_irq = |(ista_r & imask_r);

endmodule
`default_nettype wire

// file: rtl/converter_regs.svh
`ifndef CONVERTER_REGS_SVH
`define CONVERTER_REGS_SVH

// ----------------------------------------
// Register map and field positions
// ----------------------------------------
`define CTRL_ADDR 8'hd9
`define CTRL_RESET 8'h00
`define INT_STATUS_ADDR 8'he0
`define INT_MASK_ADDR 8'he1
`define BIT_DONE 7
`define BIT_BUSY 6
`define BIT_DIR 5
`define BIT_EN 4
`define BIT_ALIGN 3
`define ACK_MSB 2

// ----------------------------------------
// Timing counts
// ----------------------------------------
`define ADC_CYCLES 4'd13
`define DAC_CYCLES 4'd11
`define RC_DIV 3'd4

`endif

// file: rtl/converter_pkg.sv
package converter_pkg;
    typedef enum logic [1:0] {
        TRIG_SW = 2'h0,
        TRIG_T0 = 2'h1,
        TRIG_T1 = 2'h2,
        TRIG_T2 = 2'h3
    } trigger_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h1,
        ST_CONV = 2'h2
    } conv_state_t;
endpackage

// file: verification/conv_chk_sva.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Port checker for the converter control
// ----------------------------------------
module conv_chk (
    // Clock, reset, bus and triggers
    input wire logic i_clk, i_reset, i_wr, i_rd, i_timer0_ovf, i_timer1_ovf, i_timer2_ovf,
    input wire logic [7:0] i_addr, i_wdata, o_rdata,
    input wire logic [1:0] i_trigger_select,
    // Converter outputs
    input wire logic [15:0] o_result,
    input wire logic o_converter_enable, o_dac_mode, o_conv_clk_en, o_busy, o_irq
);
    logic [3:0] tick_r, tick_nxt;
    logic mask_r, mask_nxt, ovf;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    // Only the timer named by the trigger field may start a conversion
    assign ovf = (i_trigger_select == 2'h1 && i_timer0_ovf) ||
        (i_trigger_select == 2'h2 && i_timer1_ovf) || (i_trigger_select == 2'h3 && i_timer2_ovf);
    // Ticks counted while busy; a shadow of the done mask bit
    always_comb begin
        tick_nxt = o_busy ? tick_r + {3'h0, o_conv_clk_en} : 4'h0;
        mask_nxt = (i_wr && i_addr == 8'he1) ? i_wdata[0] : mask_r;
    end
    always_ff @(posedge i_clk) begin
        tick_r <= i_reset ? 4'h0 : tick_nxt;
        mask_r <= i_reset ? 1'b0 : mask_nxt;
    end
    sequence sw_go;
        !o_busy && o_converter_enable && i_wr && i_addr == 8'hd9 && i_wdata[6] && i_wdata[4]
            && i_trigger_select == 2'h0;
    endsequence
    // Enable still set at the fall, so this is a finish and not an abort
    sequence finish;
        $fell(o_busy) && o_converter_enable;
    endsequence
    chk_read_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("read data not zero outside a read answer");
    chk_ctrl_read: assert property (i_rd && i_addr == 8'hd9 |=>
        o_rdata[6:4] == $past({o_busy, o_dac_mode, o_converter_enable}))
        else $error("control read does not show busy, direction, enable");
    chk_sw_start: assert property (sw_go |=> o_busy)
        else $error("software start did not raise busy");
    chk_need_enable: assert property (!o_converter_enable |=> !o_busy)
        else $error("busy while converter disabled");
    chk_timer_start: assert property (!o_busy && o_converter_enable && ovf |=> o_busy)
        else $error("selected timer overflow did not start");
    chk_no_cause: assert property (!o_busy && !ovf && !i_wr |=> !o_busy)
        else $error("conversion started without a selected source");
    chk_conv_len: assert property (finish |-> tick_r == (o_dac_mode ? 4'd11 : 4'd13))
        else $error("conversion length in ticks is wrong");
    chk_done_irq: assert property (finish ##0 mask_r |-> o_irq)
        else $error("no interrupt at end of conversion");
    chk_result_hold: assert property (!$fell(o_busy) |-> $stable(o_result))
        else $error("result changed outside a conversion end");
endmodule
bind converter_start_and_control conv_chk u_conv_chk (.*);
`default_nettype wire

// file: verification/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Converter control testbench
// ----------------------------------------
module tb_top;
    logic i_clk = 1'b0, i_reset = 1'b1, i_wr = 1'b0, i_rd = 1'b0, i_rc_osc = 1'b0, m = 1'b0;
    logic i_isr_vector = 1'b0, o_converter_enable, o_dac_mode, o_conv_clk_en, o_busy, o_irq;
    logic [7:0] i_addr = 8'h00, i_wdata = 8'h00, o_rdata;
    logic [1:0] i_trigger_select = 2'h0;
    logic [2:0] ovf = 3'h0;
    logic [9:0] i_adc_raw = 10'h000;
    logic [15:0] o_result;
    int mismatches = 0, n_compared = 0, seed = 32'h9f3d47b2, k;
    // System clock and a free running RC oscillator near 8 MHz
    always #25 i_clk = ~i_clk;
    always #62 i_rc_osc = ~i_rc_osc;
    converter_start_and_control u_converter_start_and_control (.i_timer0_ovf(ovf[0]),
        .i_timer1_ovf(ovf[1]), .i_timer2_ovf(ovf[2]), .*);
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        i_addr <= a;
        i_wdata <= v;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        // Read data stands only in the cycle after the strobe
        #1 chk({8'h00, o_rdata}, {8'h00, e});
        @(posedge i_clk);
    endtask
    // Right alignment sign-extends, left alignment zero-fills
    function automatic logic [15:0] exp_res(input logic [9:0] r, input logic l);
        return l ? {r, 6'h00} : {{6{r[9]}}, r};
    endfunction
    // One conversion; a second start while busy must not stretch it
    task automatic conv(input logic [7:0] c, input logic [1:0] s);
        logic [9:0] raw;
        logic [15:0] r0;
        int n, dv, t;
        raw = 10'($random(seed));
        r0 = o_result;
        dv = c[2:0] == 3'h0 ? 10 : 1 << c[2:0];
        t = c[5] ? 11 : 13;
        i_trigger_select <= s;
        i_adc_raw <= raw;
        wr(8'hd9, c);
        if (s == 2'h0) begin
            @(posedge i_clk); // A gap so the write strobe is not reassigned
            wr(8'hd9, c | 8'h40);
        end else begin
            ovf <= ~(3'h1 << (s - 2'h1));
            @(posedge i_clk);
            #1 chk({15'h0, o_busy}, 16'h0000);
            ovf <= 3'h1 << (s - 2'h1);
            @(posedge i_clk);
            ovf <= 3'h0;
        end
        @(posedge i_clk);
        #1 chk({15'h0, o_busy}, 16'h0001);
        wr(8'hd9, c | 8'h40);
        #1;
        for (n = 2; n < 4000 && o_busy === 1'b1; n++) begin
            @(posedge i_clk);
            #1;
        end
        if (n == 4000) begin
            mismatches++;
            finish_test();
        end
        chk({15'h0, n >= t * dv - dv && n <= t * dv + dv + 4}, 16'h0001);
        chk(o_result, c[5] ? r0 : exp_res(raw, c[3]));
        chk({15'h0, o_irq}, {15'h0, m});
        rd(8'hd9, {2'b10, c[5:0]});
        i_isr_vector <= 1'b1;
        @(posedge i_clk);
        i_isr_vector <= 1'b0;
        rd(8'hd9, {2'b00, c[5:0]});
        wr(8'he0, 8'hff);
        #1 chk({15'h0, o_irq}, 16'h0000);
        $display("conversion test done, control %h trigger %0d", c, s);
    endtask
    // Reset, refusals, every clock code, both directions, every timer
    initial begin
        repeat (8) @(posedge i_clk);
        i_reset <= 1'b0;
        @(posedge i_clk);
        rd(8'hd9, 8'h00);
        rd(8'h55, 8'h00);
        wr(8'hd9, 8'hc0);
        @(posedge i_clk);
        #1 chk({15'h0, o_busy}, 16'h0000);
        rd(8'hd9, 8'h00);
        conv(8'h10, 2'h0);
        wr(8'he1, 8'h01);
        m = 1'b1;
        rd(8'he1, 8'h01);
        for (k = 1; k < 8; k++) conv(8'h10 | 8'(k) | (8'($random(seed)) & 8'h08), 2'h0);
        conv(8'h31, 2'h0);
        for (k = 1; k < 4; k++) conv(8'h12, 2'(k));
        finish_test();
    end
endmodule
`default_nettype wire
